// >>> shared/seh_pkg.sv
// shared constants and carriers for the status event hierarchy
package seh_pkg;
   // register selects on the host access port
   localparam logic [3:0] SEH_SEL_COND = 4'h0;
   localparam logic [3:0] SEH_SEL_EVT = 4'h1;
   localparam logic [3:0] SEH_SEL_ENA = 4'h2;
   localparam logic [3:0] SEH_SEL_PTR = 4'h3;
   localparam logic [3:0] SEH_SEL_NTR = 4'h4;
   localparam logic [3:0] SEH_SEL_SESR = 4'h5;
   localparam logic [3:0] SEH_SEL_ESE = 4'h6;
   localparam logic [3:0] SEH_SEL_STB = 4'h7;
   localparam logic [3:0] SEH_SEL_SRE = 4'h8;
   // group index: 0 top operation, 1..14 instruments, 15 questionable
   localparam logic [3:0] SEH_GRP_TOP = 4'h0;
   localparam logic [3:0] SEH_GRP_QUES = 4'hf;
   // live bit masks
   localparam logic [15:0] SEH_INST_MASK = 16'h43ff;
   localparam logic [15:0] SEH_TOP_MASK = 16'h7ffe;
   localparam logic [7:0] SEH_SESR_MASK = 8'hbd;
   // reset values
   localparam logic [15:0] SEH_PTR_RST = 16'hffff;
   localparam logic [15:0] SEH_NTR_RST = 16'h0000;
   localparam logic [15:0] SEH_ENA_RST = 16'h0000;
   localparam logic [15:0] SEH_EVT_RST = 16'h0000;
   localparam logic [7:0] SEH_BYTE_RST = 8'h00;
   // status byte bit positions
   localparam int SEH_STB_QUEUE = 2;
   localparam int SEH_STB_QUES = 3;
   localparam int SEH_STB_MSG = 4;
   localparam int SEH_STB_SESR = 5;
   localparam int SEH_STB_MSS = 6;
   localparam int SEH_STB_OPER = 7;

   typedef struct packed {
      logic valid;
      logic write;
      logic [3:0] sel;
      logic [3:0] grp;
      logic [15:0] wdata;
   } seh_req_s;

   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } seh_rsp_s;
endpackage

// >>> design/seh_status_tree.sv
// status event hierarchy: operation groups, standard event word, status byte
`timescale 1ns/1ps
// Behaviour
// R1: every group holds condition, event, enable, rising and falling filters; the code holds none of them for the questionable group.
// R2: instrument condition bits 0-9 and 14 live; 10-13 unused; 15 zero.
// R3: condition bits follow the instrument activity inputs with no host action.
// R4: a rising condition bit passes when its rising filter bit is one.
// R5: a falling bit passes when its falling filter is one; it only sets events.
// R6: a passing transition sets its event bit, held until the word clears.
// R7: reading an event word returns it, then clears it.
// R8: group summary is OR over bits of event AND enable.
// R9: top condition bits 1-14 carry instrument summaries; bit 15 reads zero.
// R10: top group behaves exactly like an instrument group; the code masks it to bits 1-14, not 0-9 and 14.
// R11: top operation summary drives status byte bit 7.
// R12: questionable group always reads zero; its summary bit 3 is zero.
// R13: standard event word is eight bits, cleared on read and on clear status.
// R14: standard event bits 0,2,3,4,5,7 used; bits 1 and 6 unused.
// R15: standard event enable mask selects summary driving status byte bit 5.
// R16: status byte bit 2 is one while the error queue is not empty.
// R17: status byte bit 4 is one while an output message waits.
// R18: service request enable selects byte bits forming master summary bit 6.
// R19: service request asserted while master summary is one.
// R20: reading the status byte returns it, then clears it.
// R21: reading either enable mask leaves it unchanged.
// R22: preset clears operation enables, sets rising, clears falling filters only.
// R23: bit 6 is excluded from the master summary mask AND.
// R24: reset zeroes events and enables; filters take preset values.
module seh_status_tree
   import seh_pkg::*;
#(
   parameter int NUM_INST = 14
) (
   // clock and control
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // instrument activity and message sources
   input wire logic [NUM_INST:1][15:0] inst_cond,
   input wire logic [7:0] std_event_set,
   input wire logic queue_not_empty,
   input wire logic message_waiting_flag,
   input wire logic clear_status_command,
   input wire logic status_preset,
   // host access
   input wire seh_req_s host_req,
   output seh_rsp_s host_rsp,
   // service request
   output logic service_request,
   output logic master_summary_flag
);

   // ==========================================
   // helpers
   function automatic logic group_summary(input logic [15:0] evt, input logic [15:0] ena);
      group_summary = |(evt & ena);
   endfunction

   function automatic logic [15:0] live_mask(input int idx);
      live_mask = (idx == 0) ? SEH_TOP_MASK : SEH_INST_MASK;
   endfunction

   function automatic logic grp_hit(input logic [3:0] grp, input int idx);
      grp_hit = (32'(grp) == idx);
   endfunction

   // ==========================================
   // operation group storage, index 0 is the top group
   logic [15:0] cond_prev_r [0:NUM_INST];
   logic [15:0] ptr_r [0:NUM_INST];
   logic [15:0] ntr_r [0:NUM_INST];
   logic [15:0] evt_r [0:NUM_INST];
   logic [15:0] ena_r [0:NUM_INST];
   logic [15:0] cond [0:NUM_INST];
   logic [NUM_INST:0] summ;
   logic [7:0] sesr_r;
   logic [7:0] ese_r;
   logic [7:0] sre_r;
   logic [7:0] stb_r;
   logic [7:0] stb_live;
   logic [7:0] stb_nxt;
   logic rd_acc;
   logic wr_acc;
   logic grp_ok;
   logic [15:0] rdata_nxt;
   logic [15:0] grp_rdata;
   logic [15:0] evt_pass [0:NUM_INST];
   logic [NUM_INST:0] evt_clr;
   logic [NUM_INST:0] grp_wr;
   logic rd_evt;
   logic rd_sesr;
   logic rd_stb;
   logic wr_ese;
   logic wr_sre;
   logic sesr_clr;
   logic [7:0] sesr_set;
   logic [7:0] sesr_nxt;

   assign rd_acc = host_req.valid && !host_req.write;
   assign wr_acc = host_req.valid && host_req.write;
   assign grp_ok = (32'(host_req.grp) <= NUM_INST);
   assign rd_evt = rd_acc && (host_req.sel == SEH_SEL_EVT);
   assign rd_sesr = rd_acc && (host_req.sel == SEH_SEL_SESR);
   assign rd_stb = rd_acc && (host_req.sel == SEH_SEL_STB);
   assign wr_ese = wr_acc && (host_req.sel == SEH_SEL_ESE);
   assign wr_sre = wr_acc && (host_req.sel == SEH_SEL_SRE);

   // ==========================================
   // condition words and summaries
   always_comb begin
      // summaries first so the top word sees this cycle's values
      for (int i = 0; i <= NUM_INST; i++) begin
         summ[i] = group_summary(evt_r[i], ena_r[i]); // R8
      end
      cond[0] = 16'h0000;
      for (int i = 1; i <= NUM_INST; i++) begin
         cond[i] = inst_cond[i] & SEH_INST_MASK; // R2 R3
         if (i <= 14) begin
            cond[0][i] = summ[i]; // R9 R10
         end
      end
      cond[0] = cond[0] & SEH_TOP_MASK; // R9
   end

   // ==========================================
   // per group transition and access decode
   always_comb begin
      for (int i = 0; i <= NUM_INST; i++) begin
         evt_pass[i] = (cond[i] & ~cond_prev_r[i] & ptr_r[i]) // R4
            | (~cond[i] & cond_prev_r[i] & ntr_r[i]); // R5
         evt_clr[i] = rd_evt && grp_ok && grp_hit(host_req.grp, i); // R7
         grp_wr[i] = wr_acc && grp_ok && grp_hit(host_req.grp, i);
      end
   end

   // ==========================================
   // transition detection and sticky events
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i <= NUM_INST; i++) begin
            cond_prev_r[i] <= 16'h0000;
            evt_r[i] <= SEH_EVT_RST; // R24
         end
      end else if (ce) begin
         for (int i = 0; i <= NUM_INST; i++) begin
            cond_prev_r[i] <= cond[i];
            // a passing edge wins over a same-cycle read clear
            evt_r[i] <= ((evt_clr[i] ? SEH_EVT_RST : evt_r[i]) | evt_pass[i])
               & live_mask(i); // R6 R1
         end
      end
   end

   // ==========================================
   // filters and enables
   // status preset beats a same-cycle host write
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i <= NUM_INST; i++) begin
            ptr_r[i] <= SEH_PTR_RST & live_mask(i); // R24
         end
      end else if (ce) begin
         for (int i = 0; i <= NUM_INST; i++) begin
            if (status_preset) begin
               ptr_r[i] <= SEH_PTR_RST & live_mask(i); // R22
            end else if (grp_wr[i] && host_req.sel == SEH_SEL_PTR) begin
               ptr_r[i] <= host_req.wdata & live_mask(i);
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i <= NUM_INST; i++) begin
            ntr_r[i] <= SEH_NTR_RST; // R24
         end
      end else if (ce) begin
         for (int i = 0; i <= NUM_INST; i++) begin
            if (status_preset) begin
               ntr_r[i] <= SEH_NTR_RST; // R22
            end else if (grp_wr[i] && host_req.sel == SEH_SEL_NTR) begin
               ntr_r[i] <= host_req.wdata & live_mask(i);
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i <= NUM_INST; i++) begin
            ena_r[i] <= SEH_ENA_RST; // R24
         end
      end else if (ce) begin
         for (int i = 0; i <= NUM_INST; i++) begin
            if (status_preset) begin
               ena_r[i] <= SEH_ENA_RST; // R22
            end else if (grp_wr[i] && host_req.sel == SEH_SEL_ENA) begin
               ena_r[i] <= host_req.wdata & live_mask(i);
            end
         end
      end
   end

   // ==========================================
   // standard event word and masks
   // new events win over a clear in the same cycle
   assign sesr_clr = rd_sesr || clear_status_command; // R13
   assign sesr_set = std_event_set & SEH_SESR_MASK; // R14
   assign sesr_nxt = (sesr_clr ? SEH_BYTE_RST : sesr_r) | sesr_set;

   always_ff @(posedge clk) begin
      if (rst) begin
         sesr_r <= SEH_BYTE_RST;
      end else if (ce) begin
         sesr_r <= sesr_nxt; // R13 R14
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ese_r <= SEH_BYTE_RST; // R24
      end else if (ce && wr_ese) begin
         ese_r <= host_req.wdata[7:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sre_r <= SEH_BYTE_RST; // R24
      end else if (ce && wr_sre) begin
         sre_r <= host_req.wdata[7:0];
      end
   end

   // ==========================================
   // status byte
   always_comb begin
      stb_live = 8'h00;
      stb_live[SEH_STB_QUEUE] = queue_not_empty; // R16
      stb_live[SEH_STB_QUES] = 1'b0; // R12
      stb_live[SEH_STB_MSG] = message_waiting_flag; // R17
      stb_live[SEH_STB_SESR] = |(sesr_r & ese_r); // R15
      stb_live[SEH_STB_OPER] = summ[0]; // R11
      stb_nxt = (rd_stb ? SEH_BYTE_RST : stb_r)
         | stb_live; // R20
      stb_nxt[SEH_STB_MSS] = |(stb_nxt & sre_r & ~8'h40); // R18 R23
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         stb_r <= SEH_BYTE_RST;
      end else if (ce) begin
         stb_r <= stb_nxt;
      end
   end

   assign master_summary_flag = stb_r[SEH_STB_MSS];
   assign service_request = stb_r[SEH_STB_MSS]; // R19

   // ==========================================
   // group read mux; questionable and absent groups read zero
   always_comb begin
      grp_rdata = 16'h0000;
      for (int i = 0; i <= NUM_INST; i++) begin
         if (grp_ok && grp_hit(host_req.grp, i)) begin
            case (host_req.sel)
               SEH_SEL_COND: grp_rdata = cond[i];
               SEH_SEL_EVT: grp_rdata = evt_r[i];
               SEH_SEL_ENA: grp_rdata = ena_r[i];
               SEH_SEL_PTR: grp_rdata = ptr_r[i];
               SEH_SEL_NTR: grp_rdata = ntr_r[i];
               default: grp_rdata = 16'h0000;
            endcase
         end
      end
   end

   // ==========================================
   // read path, one cycle after the request
   always_comb begin
      rdata_nxt = 16'h0000;
      case (host_req.sel)
         SEH_SEL_SESR: rdata_nxt = {8'h00, sesr_r};
         SEH_SEL_ESE: rdata_nxt = {8'h00, ese_r}; // R21
         SEH_SEL_STB: rdata_nxt = {8'h00, stb_r};
         SEH_SEL_SRE: rdata_nxt = {8'h00, sre_r}; // R21
         default: rdata_nxt = grp_rdata; // R12
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         host_rsp.valid <= 1'b0;
      end else if (ce) begin
         host_rsp.valid <= rd_acc;
      end
   end

   // data is forced to zero between answers
   always_ff @(posedge clk) begin
      if (rst) begin
         host_rsp.data <= 16'h0000;
      end else if (ce) begin
         host_rsp.data <= rd_acc ? rdata_nxt : 16'h0000; // R12
      end
   end

endmodule // seh_status_tree

// >>> sim/seh_status_tree_sva.sv
// port assertions for the status event tree
`timescale 1ns/1ps
module seh_status_tree_sva
   import seh_pkg::*;
(
   // clock and control
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // live byte sources
   input wire logic queue_not_empty,
   input wire logic message_waiting_flag,
   // host and service request
   input wire seh_req_s host_req,
   input wire seh_rsp_s host_rsp,
   input wire logic service_request,
   input wire logic master_summary_flag
);
   // ==========
   // checks
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic rd;
   logic rd_stb;
   assign rd = ce && host_req.valid && !host_req.write;
   assign rd_stb = rd && host_req.sel == SEH_SEL_STB;
   a_read_answer: assert property (rd |=> host_rsp.valid) else $error("no answer");
   a_answer_cause: assert property (host_rsp.valid && $past(ce) |-> $past(rd))
      else $error("stray answer");
   a_srq_byte: assert property (rd_stb |=> host_rsp.data[6] == $past(service_request))
      else $error("srq not in byte");
   a_srq_follow: assert property (service_request == master_summary_flag)
      else $error("srq differs");
   a_ques_zero: assert property (rd && host_req.grp == SEH_GRP_QUES
      && host_req.sel <= SEH_SEL_NTR |=> host_rsp.data == 16'h0000) else $error("ques set");
   a_cond_top: assert property (rd && host_req.sel == SEH_SEL_COND
      |=> !host_rsp.data[15]) else $error("cond bit15");
   a_stb_fixed: assert property (rd_stb |=> host_rsp.data[15:8] == 8'h00
      && !host_rsp.data[3]) else $error("stb fixed bits");
   a_stb_queue: assert property (rd_stb && queue_not_empty
      && $past(queue_not_empty && ce && !rst) |=> host_rsp.data[2]) else $error("queue bit");
   a_stb_msg: assert property (rd_stb && message_waiting_flag
      && $past(message_waiting_flag && ce && !rst) |=> host_rsp.data[4]) else $error("msg bit");
   a_sesr_unused: assert property (rd && host_req.sel == SEH_SEL_SESR
      |=> host_rsp.data[15:8] == 8'h00 && !host_rsp.data[1] && !host_rsp.data[6])
      else $error("sesr unused bits");
   a_reset_quiet: assert property (disable iff (1'b0) rst
      |=> !service_request && !host_rsp.valid) else $error("reset not quiet");
   c_stb_read: cover property (rd_stb ##1 host_rsp.valid);
   c_srq_rise: cover property ($rose(service_request));
   c_ques_read: cover property (rd && host_req.grp == SEH_GRP_QUES);
endmodule // seh_status_tree_sva

bind seh_status_tree seh_status_tree_sva seh_status_tree_sva_inst (.clk, .rst, .ce,
   .queue_not_empty, .message_waiting_flag, .host_req, .host_rsp, .service_request,
   .master_summary_flag);

// >>> sim/seh_host_model.sv
// host bus controller issuing register requests
`timescale 1ns/1ps
module seh_host_model
   import seh_pkg::*;
(
   // clock
   input wire logic clk,
   // host access
   output seh_req_s host_req,
   input wire seh_rsp_s host_rsp
);
   initial host_req = '0;
   // one request, held a cycle; answer sampled while it stands
   task automatic req(input logic w, input logic [3:0] s, g, input logic [15:0] d,
      output logic [16:0] q);
      @(negedge clk);
      host_req = '{1'b1, w, s, g, d};
      @(negedge clk);
      q = host_rsp;
      host_req = '0;
   endtask
endmodule // seh_host_model

// >>> sim/status_event_hierarchy_tb_top.sv
// self-checking bench for the status event tree
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
$display("BAD %s exp %h got %h", nm, e, g); end end
module status_event_hierarchy_tb_top
   import seh_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic [14:1][15:0] cnd = '0;
   logic [7:0] sev = 8'h00;
   logic qne = 1'b0;
   logic mwf = 1'b0;
   logic clr = 1'b0;
   logic pre = 1'b0;
   logic srq;
   logic msf;
   seh_req_s host_req;
   seh_rsp_s host_rsp;
   int n_mismatch = 0;
   int checked = 0;
   always #12.5 clk = ~clk;
   seh_status_tree seh_status_tree_inst (.clk, .rst, .ce, .inst_cond(cnd), .std_event_set(sev),
      .queue_not_empty(qne), .message_waiting_flag(mwf), .clear_status_command(clr),
      .status_preset(pre), .host_req, .host_rsp, .service_request(srq),
      .master_summary_flag(msf));
   seh_host_model seh_host_model_inst (.clk, .host_req, .host_rsp);
   // ==========
   // tasks
   task automatic wr(input logic [3:0] s, g, input logic [15:0] d);
      logic [16:0] q;
      seh_host_model_inst.req(1'b1, s, g, d, q);
   endtask
   task automatic rc(input string nm, input logic [3:0] s, g, input logic [15:0] e);
      logic [16:0] q;
      seh_host_model_inst.req(1'b0, s, g, 16'h0000, q);
      `CHK(nm, {1'b1, e}, q)
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask
   task report_and_stop;
      $display("checked %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ==========
   // tests
   initial begin
      idle(6);
      rst = 1'b0;
      rc("ptr1", SEH_SEL_PTR, 4'h1, 16'h43ff);
      rc("ptr0", SEH_SEL_PTR, SEH_GRP_TOP, 16'h7ffe);
      cnd[1] = 16'h0010;
      idle(3);
      rc("rise", SEH_SEL_EVT, 4'h1, 16'h0010);
      rc("rdclr", SEH_SEL_EVT, 4'h1, 16'h0000);
      wr(SEH_SEL_NTR, 4'h1, 16'h0010);
      cnd[1] = 16'h0000;
      idle(3);
      rc("fall", SEH_SEL_EVT, 4'h1, 16'h0010);
      $display("transition test done");
      wr(SEH_SEL_ENA, 4'h1, 16'h0010);
      wr(SEH_SEL_ENA, SEH_GRP_TOP, 16'h0002);
      wr(SEH_SEL_SRE, 4'h0, 16'h0080);
      cnd[1] = 16'h0010;
      idle(6);
      `CHK("srq", 1'b1, srq)
      `CHK("msf", 1'b1, msf)
      rc("top", SEH_SEL_COND, SEH_GRP_TOP, 16'h0002);
      rc("stb", SEH_SEL_STB, 4'h0, 16'h00c0);
      rc("sre", SEH_SEL_SRE, 4'h0, 16'h0080);
      $display("summary test done");
      pre = 1'b1;
      idle(1);
      pre = 1'b0;
      qne = 1'b1;
      mwf = 1'b1;
      idle(2);
      rc("pena", SEH_SEL_ENA, 4'h1, 16'h0000);
      rc("pntr", SEH_SEL_NTR, 4'h1, 16'h0000);
      rc("psre", SEH_SEL_SRE, 4'h0, 16'h0080);
      rc("stb0", SEH_SEL_STB, 4'h0, 16'h00d4);
      rc("stb1", SEH_SEL_STB, 4'h0, 16'h0014);
      wr(SEH_SEL_SRE, 4'h0, 16'h0050);
      idle(1);
      `CHK("mss4", 1'b1, srq)
      wr(SEH_SEL_SRE, 4'h0, 16'h0040);
      idle(2);
      `CHK("mss6", 1'b0, srq)
      qne = 1'b0;
      mwf = 1'b0;
      $display("preset test done");
      wr(SEH_SEL_ESE, 4'h0, 16'h0020);
      wr(SEH_SEL_SRE, 4'h0, 16'h0020);
      sev = 8'h22;
      idle(1);
      sev = 8'h00;
      idle(3);
      `CHK("srq2", 1'b1, srq)
      rc("sesr", SEH_SEL_SESR, 4'h0, 16'h0020);
      sev = 8'h01;
      idle(1);
      sev = 8'h00;
      clr = 1'b1;
      idle(1);
      clr = 1'b0;
      rc("cls", SEH_SEL_SESR, 4'h0, 16'h0000);
      idle(1);
      ce = 1'b0;
      sev = 8'h20;
      idle(1);
      sev = 8'h00;
      idle(1);
      ce = 1'b1;
      rc("frz", SEH_SEL_SESR, 4'h0, 16'h0000);
      wr(SEH_SEL_ENA, SEH_GRP_QUES, 16'hffff);
      rc("ques", SEH_SEL_ENA, SEH_GRP_QUES, 16'h0000);
      cnd[2] = 16'hffff;
      idle(2);
      rc("cond2", SEH_SEL_COND, 4'h2, 16'h43ff);
      $display("event word test done");
      report_and_stop();
   end
   initial begin
      #(25 * 2000);
      n_mismatch++;
      report_and_stop();
   end
endmodule // status_event_hierarchy_tb_top
